// [rtl/rvs_pkg.sv]
// rvs_pkg.sv: constants, types and behaviour notes for the verify/stream block
package rvs_pkg;
  // ****************************************************************
  // command codes and task-file bit positions
  // ****************************************************************
  localparam logic [7:0] CMD_VERIFY = 8'h40;
  localparam logic [7:0] CMD_VERIFY_ALT = 8'h41;
  localparam logic [7:0] CMD_VERIFY_EXT = 8'h42;
  localparam logic [7:0] CMD_STREAM_READ = 8'h2a;
  localparam int ERR_CTL_BIT = 0;
  localparam int ERR_ABORT_BIT = 2;
  localparam int ERR_NOTFOUND_BIT = 4;
  localparam int ERR_UNCORR_BIT = 6;
  localparam int ST_ERR_BIT = 0;
  localparam int ST_STREAM_BIT = 5;
  localparam int ST_RDY_BIT = 6;
  localparam int ST_BSY_BIT = 7;
  localparam int DEV_LBA_BIT = 6;
  localparam logic [7:0] STATUS_RESET = 8'h40;
  // ****************************************************************
  // register map (byte index on the plain port)
  // ****************************************************************
  localparam logic [3:0] REG_ERROR = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_CNT_LO = 4'h2;
  localparam logic [3:0] REG_CNT_HI = 4'h3;
  localparam logic [3:0] REG_LBA0 = 4'h4;
  localparam logic [3:0] REG_LBA1 = 4'h5;
  localparam logic [3:0] REG_LBA2 = 4'h6;
  localparam logic [3:0] REG_LBA3 = 4'h7;
  localparam logic [3:0] REG_LBA4 = 4'h8;
  localparam logic [3:0] REG_LBA5 = 4'h9;
  localparam logic [3:0] REG_LOG = 4'ha;
  localparam logic [3:0] REG_IRQ_STAT = 4'hb;
  localparam logic [3:0] REG_IRQ_MASK = 4'hc;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  // irq bits: 0 done ok, 1 error, 2 stream error
  localparam int IRQ_W = 3;
  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic [7:0] code;
    logic [7:0] device;
    logic [15:0] count;
    logic [47:0] lba;
    logic rd_cont;
  } rvs_cmd_type;
  typedef struct packed {
    logic ok;
    logic uncorr;
    logic not_found;
    logic aborted;
  } rvs_sect_type;
  typedef enum logic [1:0] {IDLE, REQ, WAIT} rvs_state_type;
endpackage : rvs_pkg

// [rtl/rvs_core.sv]
// rvs_core.sv: verify and stream-read command sequencer with task-file regs
//
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/10ps
module rvs_core (
  // clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RST_B_I,
  // command issue
  input wire logic CMD_VALID_I,
  input wire rvs_pkg::rvs_cmd_type CMD_I,
  // medium sector check
  output logic SECT_REQ_O,
  output logic [47:0] SECT_LBA_O,
  output logic SECT_XFER_O,
  input wire logic SECT_DONE_I,
  input wire rvs_pkg::rvs_sect_type SECT_RES_I,
  // completion time limit expiry
  input wire logic TIME_LIMIT_I,
  // register port
  input wire logic [3:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [7:0] REG_RDATA_O,
  // interrupt
  output logic IRQ_O
);
  import rvs_pkg::*;

  // ****************************************************************
  // command state
  // ****************************************************************
  rvs_state_type state_q;
  rvs_cmd_type cmd_q;
  logic [16:0] left_q;
  logic [47:0] lba_q;
  logic [47:0] bad_lba_q;
  logic [15:0] bad_cnt_q;
  logic [7:0] err_q;
  logic [7:0] status_q;
  logic [7:0] log_q;
  logic [IRQ_W-1:0] irq_st_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [7:0] rdata_q;

  function automatic logic is_verify(input logic [7:0] code);
    is_verify = (code == CMD_VERIFY) || (code == CMD_VERIFY_ALT)
      || (code == CMD_VERIFY_EXT);
  endfunction : is_verify

  // zero count expands to full range
  function automatic logic [16:0] full_count(input rvs_cmd_type c);
    if (c.code == CMD_VERIFY || c.code == CMD_VERIFY_ALT) begin
      full_count = (c.count[7:0] == 8'h00) ? 17'h00100
        : {9'h000, c.count[7:0]};
    end else begin
      full_count = (c.count == 16'h0000) ? 17'h10000 : {1'b0, c.count};
    end
  endfunction : full_count

  // ****************************************************************
  // decode
  // ****************************************************************
  wire start = (state_q == IDLE) && CMD_VALID_I;
  // extended verify relies on lba mode bit from host
  wire cmd_ok = (CMD_I.code == CMD_VERIFY_EXT) ? CMD_I.device[DEV_LBA_BIT]
    : (is_verify(CMD_I.code) || CMD_I.code == CMD_STREAM_READ);
  wire sect_bad = SECT_RES_I.uncorr || SECT_RES_I.not_found
    || SECT_RES_I.aborted;
  // result bits only count in the cycle the medium reports
  wire res_v = (state_q == WAIT) && SECT_DONE_I;
  wire busy = (state_q != IDLE);
  wire tlimit = busy && TIME_LIMIT_I;
  wire fail = (state_q == WAIT && SECT_DONE_I && sect_bad) || tlimit;
  wire last = (state_q == WAIT) && SECT_DONE_I && !sect_bad
    && (left_q == 17'h00001);
  wire [7:0] fail_bits = {1'b0, res_v && SECT_RES_I.uncorr, 1'b0,
    res_v && SECT_RES_I.not_found, 1'b0, res_v && SECT_RES_I.aborted,
    1'b0, tlimit};
  wire stream_err = fail && cmd_q.rd_cont;
  wire wr_irq = REG_WR_I && (REG_ADDR_I == REG_IRQ_STAT);
  wire [IRQ_W-1:0] irq_ev = {stream_err, fail && !cmd_q.rd_cont, last};

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_B_I) begin
      state_q <= IDLE;
      cmd_q <= '0;
      left_q <= '0;
      lba_q <= '0;
    end else begin
      case (state_q)
        IDLE: begin
          if (start && cmd_ok) begin
            cmd_q <= CMD_I;
            left_q <= full_count(CMD_I);
            lba_q <= CMD_I.lba;
            state_q <= REQ;
          end
        end
        REQ: state_q <= tlimit ? IDLE : WAIT;
        WAIT: begin
          if (fail || last) begin
            state_q <= IDLE;
          end else if (SECT_DONE_I) begin
            left_q <= left_q - 17'h00001;
            lba_q <= lba_q + 48'h1;
            state_q <= REQ;
          end
        end
        default: state_q <= IDLE;
      endcase
    end
  end

  // ****************************************************************
  // task-file results
  // ****************************************************************
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_B_I) begin
      err_q <= '0;
      status_q <= STATUS_RESET;
      log_q <= '0;
      bad_lba_q <= '0;
      bad_cnt_q <= '0;
    end else if (start) begin
      err_q <= cmd_ok ? 8'h00 : (8'h01 << ERR_ABORT_BIT);
      status_q <= cmd_ok ? 8'h80 : 8'h41;
    end else if (fail) begin
      // first bad address and suspect count
      bad_lba_q <= lba_q;
      bad_cnt_q <= left_q[15:0];
      if (cmd_q.rd_cont) begin
        // stream error: log instead of error register
        log_q <= fail_bits;
        err_q <= 8'h00;
        // stream error flag, error bit clear
        status_q <= (8'h01 << ST_STREAM_BIT) | (8'h01 << ST_RDY_BIT);
      end else begin
        // time-limit flag lands in bit 0
        err_q <= fail_bits;
        status_q <= (8'h01 << ST_ERR_BIT) | (8'h01 << ST_RDY_BIT);
      end
    end else if (last) begin
      status_q <= 8'h01 << ST_RDY_BIT;
    end
  end

  // ****************************************************************
  // interrupt status and mask
  // ****************************************************************
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_B_I) begin
      irq_st_q <= '0;
      irq_mask_q <= '0;
    end else begin
      // set beats a same-cycle write-one clear
      irq_st_q <= (irq_st_q & ~(wr_irq ? REG_WDATA_I[IRQ_W-1:0] : '0))
        | irq_ev;
      if (REG_WR_I && REG_ADDR_I == REG_IRQ_MASK) begin
        irq_mask_q <= REG_WDATA_I[IRQ_W-1:0];
      end
    end
  end
  assign IRQ_O = |(irq_st_q & irq_mask_q);

  // ****************************************************************
  // register read
  // ****************************************************************
  logic [7:0] rd_mux;
  always_comb begin
    case (REG_ADDR_I)
      REG_ERROR: rd_mux = err_q;
      REG_STATUS: rd_mux = status_q;
      REG_CNT_LO: rd_mux = bad_cnt_q[7:0];
      REG_CNT_HI: rd_mux = bad_cnt_q[15:8];
      REG_LBA0: rd_mux = bad_lba_q[7:0];
      REG_LBA1: rd_mux = bad_lba_q[15:8];
      REG_LBA2: rd_mux = bad_lba_q[23:16];
      REG_LBA3: rd_mux = bad_lba_q[31:24];
      REG_LBA4: rd_mux = bad_lba_q[39:32];
      REG_LBA5: rd_mux = bad_lba_q[47:40];
      REG_LOG: rd_mux = log_q;
      REG_IRQ_STAT: rd_mux = {5'h00, irq_st_q};
      REG_IRQ_MASK: rd_mux = {5'h00, irq_mask_q};
      default: rd_mux = RD_UNMAPPED;
    endcase
  end
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_B_I) begin
      rdata_q <= '0;
    end else if (REG_RD_I) begin
      rdata_q <= rd_mux;
    end
  end
  assign REG_RDATA_O = rdata_q;

  // ****************************************************************
  // medium side
  // ****************************************************************
  assign SECT_REQ_O = (state_q == REQ) && !tlimit;
  assign SECT_LBA_O = lba_q;
  // verify never transfers data; stream read does
  assign SECT_XFER_O = busy && !is_verify(cmd_q.code);
endmodule : rvs_core

// [testbench/rvs_core_sva.sv]
// assertions on the verify sequencer ports
`timescale 1ns/10ps
module rvs_core_sva
  import rvs_pkg::*;
(
  // clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RST_B_I,
  // command and medium side
  input wire logic CMD_VALID_I,
  input wire rvs_pkg::rvs_cmd_type CMD_I,
  input wire logic SECT_REQ_O,
  input wire logic [47:0] SECT_LBA_O,
  input wire logic SECT_XFER_O,
  input wire logic SECT_DONE_I,
  input wire rvs_pkg::rvs_sect_type SECT_RES_I,
  input wire logic TIME_LIMIT_I
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_B_I);
  // ****
  // sequences
  // ****
  sequence vfy_go_s;
    CMD_VALID_I && CMD_I.code == CMD_VERIFY;
  endsequence
  sequence ext_go_s;
    CMD_VALID_I && CMD_I.code == CMD_VERIFY_EXT;
  endsequence
  sequence good_next_s;
    SECT_DONE_I && SECT_RES_I.ok ##1 SECT_REQ_O;
  endsequence
  // ****
  // properties
  // ****
  start_lba_a: assert property (
    vfy_go_s |=> SECT_REQ_O && SECT_LBA_O == $past(CMD_I.lba))
    else $error("verify did not start at its address");
  req_pulse_a: assert property (SECT_REQ_O |=> !SECT_REQ_O)
    else $error("sector request longer than one cycle");
  lba_step_a: assert property (
    good_next_s |-> SECT_LBA_O == $past(SECT_LBA_O) + 48'h1)
    else $error("sector address did not step by one");
  ext_run_a: assert property (
    ext_go_s and CMD_I.device[DEV_LBA_BIT] |=> SECT_REQ_O ##1 !SECT_REQ_O)
    else $error("extended verify did not start");
  ext_refuse_a: assert property (
    ext_go_s and !CMD_I.device[DEV_LBA_BIT] |=> !SECT_REQ_O [*3])
    else $error("extended verify ran without the address bit");
  no_xfer_a: assert property (
    CMD_VALID_I && CMD_I.code != CMD_STREAM_READ |=> !SECT_XFER_O [*4])
    else $error("verify moved sector data");
  unc_stop_a: assert property (
    SECT_DONE_I && SECT_RES_I.uncorr |=> !SECT_REQ_O [*4])
    else $error("verify went past an uncorrectable sector");
  tlim_stop_a: assert property (
    TIME_LIMIT_I && !SECT_DONE_I |=> !SECT_REQ_O [*3])
    else $error("run continued after the time limit");
endmodule : rvs_core_sva
bind rvs_core rvs_core_sva rvs_core_sva_i (.CORE_CLK_I, .RST_B_I,
  .CMD_VALID_I, .CMD_I, .SECT_REQ_O, .SECT_LBA_O, .SECT_XFER_O,
  .SECT_DONE_I, .SECT_RES_I, .TIME_LIMIT_I);

// [testbench/rvs_medium.sv]
// medium model answering sector checks
`timescale 1ns/10ps
module rvs_medium
  import rvs_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // sector check
  input wire logic req_i,
  input wire logic [47:0] lba_i,
  output logic done_o,
  output rvs_pkg::rvs_sect_type res_o,
  // fault setup: kind 0 none, 1 unc, 2 id_not_found_error, 3 command_aborted_error
  input wire logic [47:0] bad_lba_i,
  input wire logic [1:0] kind_i,
  input wire logic [3:0] lag_i
);
  logic [3:0] cnt_q;
  logic busy_q;
  logic hit;
  assign hit = lba_i == bad_lba_i && kind_i != 2'h0;
  // result toggles outside done so stale values never look valid
  always_ff @(posedge clk_i) begin
    done_o <= 1'b0;
    res_o <= ~res_o;
    if (!rst_b_i) begin
      busy_q <= 1'b0;
      cnt_q <= 4'h0;
    end else if (req_i) begin
      busy_q <= 1'b1;
      cnt_q <= lag_i;
    end else if (busy_q && cnt_q == 4'h0) begin
      busy_q <= 1'b0;
      done_o <= 1'b1;
      res_o <= '{!hit, hit && kind_i == 2'h1, hit && kind_i == 2'h2,
                 hit && kind_i == 2'h3};
    end else if (busy_q) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end
endmodule : rvs_medium

// [testbench/rvs_core_bench.sv]
// self-checking bench for the verify sequencer
`timescale 1ns/10ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("wrong value t=%0t got %h exp %h", $time, a, e); end end
module rvs_core_bench;
  import rvs_pkg::*;
  logic CORE_CLK_I = 1'b0, RST_B_I = 1'b0, CMD_VALID_I = 1'b0;
  logic REG_WR_I = 1'b0, REG_RD_I = 1'b0, TIME_LIMIT_I = 1'b0;
  logic SECT_REQ_O, SECT_XFER_O, SECT_DONE_I, IRQ_O;
  logic [3:0] REG_ADDR_I = 4'h0, lag = 4'h0;
  logic [7:0] REG_WDATA_I = 8'h00, REG_RDATA_O;
  logic [47:0] SECT_LBA_O, bad = 48'h0;
  logic [1:0] kind = 2'h0;
  rvs_cmd_type CMD_I = '0;
  rvs_sect_type SECT_RES_I;
  int error_cnt = 0, n_checks = 0, reqs = 0, xfers = 0;
  rvs_core rvs_core_i (.CORE_CLK_I, .RST_B_I, .CMD_VALID_I, .CMD_I,
    .SECT_REQ_O, .SECT_LBA_O, .SECT_XFER_O, .SECT_DONE_I, .SECT_RES_I,
    .TIME_LIMIT_I, .REG_ADDR_I, .REG_WDATA_I, .REG_WR_I, .REG_RD_I,
    .REG_RDATA_O, .IRQ_O);
  rvs_medium rvs_medium_i (.clk_i(CORE_CLK_I), .rst_b_i(RST_B_I),
    .req_i(SECT_REQ_O), .lba_i(SECT_LBA_O), .done_o(SECT_DONE_I),
    .res_o(SECT_RES_I), .bad_lba_i(bad), .kind_i(kind), .lag_i(lag));
  always #25 CORE_CLK_I = ~CORE_CLK_I;
  always @(posedge CORE_CLK_I) begin
    reqs += SECT_REQ_O;
    xfers += SECT_XFER_O;
  end
  // ****
  // bus and command helpers
  // ****
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge CORE_CLK_I) {REG_ADDR_I, REG_WDATA_I, REG_WR_I} <= {a, d, 1'b1};
    @(posedge CORE_CLK_I) REG_WR_I <= 1'b0;
    #1;
  endtask : wr
  task automatic chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge CORE_CLK_I) {REG_ADDR_I, REG_RD_I} <= {a, 1'b1};
    @(posedge CORE_CLK_I) REG_RD_I <= 1'b0;
    #1 `CHK(REG_RDATA_O, e)
  endtask : chk
  task automatic issue(input logic [7:0] c, input logic [7:0] dv,
      input logic [15:0] n, input logic [47:0] l, input logic r);
    @(posedge CORE_CLK_I) {CMD_I, CMD_VALID_I} <= {c, dv, n, l, r, 1'b1};
    reqs = 0;
    @(posedge CORE_CLK_I) CMD_VALID_I <= 1'b0;
  endtask : issue
  // idle poll is bounded; a hang shows up as wrong status
  task automatic fin(input logic [7:0] e, input logic [7:0] s, input int n);
    for (int i = 0; i < 3000 && rvs_core_i.REG_RDATA_O[ST_BSY_BIT] !== 1'b0
        || i == 0; i++) begin
      @(posedge CORE_CLK_I) {REG_ADDR_I, REG_RD_I} <= {REG_STATUS, 1'b1};
      @(posedge CORE_CLK_I) REG_RD_I <= 1'b0;
      #1;
    end
    chk(REG_ERROR, e);
    chk(REG_STATUS, s);
    `CHK(reqs, n)
  endtask : fin
  // ****
  // scenarios
  // ****
  task automatic good_short;
    wr(REG_IRQ_MASK, 8'h07);
    issue(CMD_VERIFY, 8'h40, 16'h0003, 48'h0000_0000_10fe, 1'b0);
    fin(8'h00, STATUS_RESET, 3);
    `CHK(IRQ_O, 1'b1)
    wr(REG_IRQ_STAT, 8'h01);
    `CHK(IRQ_O, 1'b0)
  endtask : good_short
  task automatic counts;
    issue(CMD_VERIFY, 8'h40, 16'h0100, 48'h0000_0001_0000, 1'b0);
    fin(8'h00, STATUS_RESET, 256);
    issue(CMD_VERIFY_ALT, 8'h40, 16'h0002, 48'h0000_0003_0000, 1'b0);
    fin(8'h00, STATUS_RESET, 2);
    issue(CMD_VERIFY_EXT, 8'h40, 16'h0102, 48'h0000_0002_0000, 1'b0);
    fin(8'h00, STATUS_RESET, 258);
    issue(CMD_VERIFY_EXT, 8'h00, 16'h0002, 48'h0, 1'b0);
    fin(8'h04, 8'h41, 0);
  endtask : counts
  task automatic unc_stop;
    {bad, kind, lag} = {48'ha1b2_c3d4_e5f2, 2'h1, 4'h2};
    wr(REG_IRQ_STAT, 8'h07);
    wr(REG_IRQ_MASK, 8'h00);
    issue(CMD_VERIFY, 8'h40, 16'h0005, 48'ha1b2_c3d4_e5f0, 1'b0);
    fin(8'h40, 8'h41, 3);
    for (int i = 0; i < 6; i++) chk(REG_LBA0 + 4'(i), bad[8*i+:8]);
    chk(REG_CNT_LO, 8'h03);
    chk(REG_IRQ_STAT, 8'h02);
    `CHK(IRQ_O, 1'b0)
  endtask : unc_stop
  task automatic rc_id_not_found_error;
    {bad, kind} = {48'h0000_0000_0777, 2'h2};
    issue(CMD_VERIFY, 8'h40, 16'h0004, 48'h0000_0000_0777, 1'b1);
    fin(8'h00, 8'h60, 1);
    chk(REG_LOG, 8'h10);
  endtask : rc_id_not_found_error
  task automatic tlim;
    {kind, lag} = {2'h0, 4'h8};
    issue(CMD_VERIFY, 8'h40, 16'h0004, 48'h0, 1'b0);
    repeat (3) @(posedge CORE_CLK_I);
    TIME_LIMIT_I <= 1'b1;
    @(posedge CORE_CLK_I) TIME_LIMIT_I <= 1'b0;
    fin(8'h01, 8'h41, 1);
  endtask : tlim
  task automatic give_verdict;
    $display("errors %0d checks %0d", error_cnt, n_checks);
    if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (12) @(posedge CORE_CLK_I);
    RST_B_I <= 1'b1;
    chk(REG_STATUS, STATUS_RESET);
    chk(4'hd, RD_UNMAPPED);
    good_short;
    counts;
    unc_stop;
    rc_id_not_found_error;
    tlim;
    `CHK(xfers, 0)
    give_verdict;
  end
  initial begin
    #2000000;
    error_cnt++;
    give_verdict;
  end
endmodule : rvs_core_bench
